// ### common/fepc_params.svh
/*
  Constants of the fast ethernet coding path: code-groups, scrambler
  layout, lock and hold-timer figures. Included by package and modules except fepc_buf.
*/
`ifndef FEPC_PARAMS_SVH
`define FEPC_PARAMS_SVH

`define FEPC_NIB_W        4
`define FEPC_SYM_W        5
`define FEPC_CODE_IDLE    5'h1f
`define FEPC_CODE_J       5'h18
`define FEPC_CODE_K       5'h11
`define FEPC_CODE_T       5'h0d
`define FEPC_CODE_R       5'h07
`define FEPC_CODE_HALT    5'h04
`define FEPC_LFSR_W       11
`define FEPC_TAP_HI       10
`define FEPC_TAP_LO       8
`define FEPC_SEED_FILL    7'h55
`define FEPC_CLK_MHZ      40
`define FEPC_HOLD_US      722
`define FEPC_HOLD_CYCLES  (`FEPC_HOLD_US * `FEPC_CLK_MHZ)
`define FEPC_LOCK_IDLES   12
`define FEPC_LOCK_BITS    (`FEPC_LOCK_IDLES * `FEPC_SYM_W)
`define FEPC_MON_BITS     58
`define FEPC_BUF_DEPTH    2

`endif

// ### common/fepc_pkg.sv
/*
  Types of the fast ethernet coding path.
  Assumes fepc_params.svh is on the include path.
*/
`default_nettype none
`include "fepc_params.svh"

package fepc_pkg;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_J    = 3'b001,
    TX_K    = 3'b010,
    TX_DATA = 3'b011,
    TX_T    = 3'b100,
    TX_R    = 3'b101
  } fepc_tx_state_t;

  typedef struct packed {
    logic                   en;
    logic [`FEPC_NIB_W-1:0] nib;
  } fepc_mac_word_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } fepc_line_t;

  typedef struct packed {
    logic [`FEPC_SYM_W-1:0] sym;
    logic [`FEPC_NIB_W-1:0] nib;
    logic                   is_data;
  } fepc_rx_word_t;

endpackage

`default_nettype wire

// ### hdl/fepc_buf.sv
/*
  Small ring buffer with valid/ready on both sides; ready and valid come
  from flip-flops. Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module fepc_buf #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_in,       // clock
  input  wire logic             reset_n_in,   // async reset, low
  input  wire logic [WIDTH-1:0] in_data_in,   // write data
  input  wire logic             in_valid_in,  // write request
  output logic                  in_ready_out, // room left
  output logic      [WIDTH-1:0] out_data_out, // head entry
  output logic                  out_valid_out,// head valid
  input  wire logic             out_ready_in  // head taken
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fepc_buf: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;
  logic [PW:0]      next_count;

  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (PW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      count         <= next_count;
      in_ready_out  <= next_count != (PW+1)'(DEPTH);
      out_valid_out <= next_count != '0;
    end
  end
endmodule // fepc_buf

`default_nettype wire

// ### hdl/fepc_core.sv
/*
  Fast ethernet coding path: 4B/5B encoder with delimiters and idle fill,
  scrambler, NRZI and MLT-3 split on transmit; MLT-3/NRZI decode,
  descrambler lock with hold timer, 5-bit grouping on receive.
  Assumes one bit time per clock, nibble words from a MAC over valid/ready,
  and line streams already equalised and sampled on clk_in.
//
// Functional notes
// - each MAC nibble becomes one 5-bit code-group
// - frame start sends J then K
// - later nibbles encoded while frame lasts
// - enable dropping ends frame with T, R
// - idle code-groups fill between frames
// - 11-bit LFSR key xored onto serial stream
// - scrambler seed taken from address straps 4:1
// - scrambled stream NRZI encoded before line stage
// - NRZI ones alternate between two line streams
// - transmit line carries only MLT-3 coding
// - receive path turns line into nibbles
// - link pulses alone keep signal detect low
// - MLT-3 to NRZI, then NRZI to NRZ
// - received bits grouped into 5-bit symbols
// - descrambler key matches far-end scrambler
// - lock after twelve consecutive idle groups
// - lock starts 722 us hold countdown
// - 58 idle bits restart the countdown
// - hold expiry drops lock, full restart
// - data nibbles use the fixed 4B/5B table
// - idle is 11111, halt 00100
*/
`timescale 1ns/1ps
`default_nettype none

`include "fepc_params.svh"

module fepc_core
  import fepc_pkg::*;
#(
  parameter int HOLD_CYCLES = `FEPC_HOLD_CYCLES,
  parameter int BUF_DEPTH   = `FEPC_BUF_DEPTH
) (
  input  wire logic           clk_in,                 // bit clock
  input  wire logic           reset_n_in,             // async reset, low
  input  wire logic [4:0]     station_address_straps_in, // address straps
  input  wire fepc_mac_word_t mac_tx_in,              // enable and nibble
  input  wire logic           mac_tx_valid_in,        // word offered
  output logic                mac_tx_ready_out,       // word accepted
  output fepc_line_t          tx_line_out,            // MLT-3 pair
  input  wire fepc_line_t     rx_line_in,             // sliced MLT-3 pair
  input  wire logic           rx_energy_in,           // line energy seen
  input  wire logic           rx_link_pulse_in,       // NLP/FLP activity
  output logic                signal_detect_out,      // 100M signal
  output logic                rx_locked_out,          // descrambler lock
  output fepc_rx_word_t       rx_word_out,            // symbol and nibble
  output logic                rx_word_valid_out       // one-cycle strobe
);
  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES - 1);
  localparam logic [5:0] LOCK_LAST = 6'(`FEPC_LOCK_BITS - 1);
  localparam logic [5:0] MON_LAST  = 6'(`FEPC_MON_BITS - 1);

  generate
    if (HOLD_CYCLES < 2) begin : g_bad_hold
      $error("fepc_core: HOLD_CYCLES must be at least 2");
    end
  endgenerate

  function automatic logic [4:0] fepc_encode(input logic [3:0] nib);
    logic [4:0] code;
    case (nib)
      4'h0: code = 5'h1e;
      4'h1: code = 5'h09;
      4'h2: code = 5'h14;
      4'h3: code = 5'h15;
      4'h4: code = 5'h0a;
      4'h5: code = 5'h0b;
      4'h6: code = 5'h0e;
      4'h7: code = 5'h0f;
      4'h8: code = 5'h12;
      4'h9: code = 5'h13;
      4'ha: code = 5'h16;
      4'hb: code = 5'h17;
      4'hc: code = 5'h1a;
      4'hd: code = 5'h1b;
      4'he: code = 5'h1c;
      default: code = 5'h1d;
    endcase
    return code;
  endfunction

  // inverse table; anything else is control or invalid
  function automatic logic [4:0] fepc_decode(input logic [4:0] sym);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (fepc_encode(4'(i)) == sym) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  // ---- transmit ----
  fepc_mac_word_t head;
  logic           head_valid;
  logic           pop;
  logic           next_pop;
  logic [2:0]     bit_cnt;
  logic           boundary;
  fepc_tx_state_t tx_state;
  fepc_tx_state_t next_state;
  logic [4:0]     tx_sym;
  logic [4:0]     next_sym;
  logic [4:0]     tx_sr;
  logic [10:0]    scr;
  logic           scr_key;
  logic           scr_bit;
  logic           seeded;
  logic           nrzi;
  logic           phase;

  fepc_buf #(
    .WIDTH ($bits(fepc_mac_word_t)),
    .DEPTH (BUF_DEPTH)
  ) u_txbuf (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_data_in    (mac_tx_in),
    .in_valid_in   (mac_tx_valid_in),
    .in_ready_out  (mac_tx_ready_out),
    .out_data_out  (head),
    .out_valid_out (head_valid),
    .out_ready_in  (pop)
  );

  assign boundary = (bit_cnt == 3'h4);
  assign pop      = boundary && next_pop;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= boundary ? 3'h0 : bit_cnt + 3'h1;
    end
  end

  always_comb begin
    next_state = tx_state;
    next_sym   = `FEPC_CODE_IDLE;
    next_pop   = 1'b0;
    case (tx_state)
      TX_IDLE, TX_R: begin
        if (head_valid && head.en) begin
          next_sym   = `FEPC_CODE_J;
          next_state = TX_J;
          next_pop   = 1'b1;
        end else begin
          next_sym   = `FEPC_CODE_IDLE;
          next_state = TX_IDLE;
          next_pop   = head_valid;
        end
      end
      TX_J: begin
        next_sym   = `FEPC_CODE_K;
        next_state = TX_K;
        next_pop   = head_valid;
      end
      TX_K, TX_DATA: begin
        if (head_valid && head.en) begin
          next_sym   = fepc_encode(head.nib);
          next_state = TX_DATA;
          next_pop   = 1'b1;
        end else begin
          // an empty buffer also ends the frame: no stretching on underrun
          next_sym   = `FEPC_CODE_T;
          next_state = TX_T;
          next_pop   = head_valid;
        end
      end
      TX_T: begin
        next_sym   = `FEPC_CODE_R;
        next_state = TX_R;
        next_pop   = head_valid && !head.en;
      end
      default: begin
        next_sym   = `FEPC_CODE_IDLE;
        next_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_state <= TX_IDLE;
      tx_sym   <= `FEPC_CODE_IDLE;
      tx_sr    <= `FEPC_CODE_IDLE;
    end else if (boundary) begin
      tx_state <= next_state;
      tx_sym   <= next_sym;
      tx_sr    <= next_sym;
    end else begin
      tx_sr    <= {tx_sr[3:0], 1'b0};
    end
  end

  assign scr_key = scr[`FEPC_TAP_HI] ^ scr[`FEPC_TAP_LO];
  assign scr_bit = tx_sr[4] ^ scr_key;

  // seed is caught after reset release; straps are not sampled under reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seeded <= 1'b0;
      scr    <= 11'h7ff;
    end else if (!seeded) begin
      seeded <= 1'b1;
      scr    <= {station_address_straps_in[4:1], `FEPC_SEED_FILL};
    end else begin
      scr    <= {scr[9:0], scr_key};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nrzi        <= 1'b0;
      phase       <= 1'b0;
      tx_line_out <= '0;
    end else begin
      nrzi        <= nrzi ^ scr_bit;
      // legs swap only after a run ends, so the pair never jumps pos to neg
      phase       <= phase ^ (!nrzi && (tx_line_out.pos || tx_line_out.neg));
      // only the MLT-3 pair exists; no binary mode is offered
      tx_line_out <= '{pos: nrzi && !phase, neg: nrzi && phase};
    end
  end

  // ---- receive ----
  logic        rx_nrzi;
  logic        rx_prev;
  logic        rx_nrz;
  logic [10:0] dsc;
  logic        dsc_key;
  logic        ud;
  logic [5:0]  lock_run;
  logic [5:0]  mon_run;
  logic [HOLD_W-1:0] hold;
  logic [2:0]  rx_cnt;
  logic [3:0]  rx_acc;
  logic [4:0]  next_rx_sym;
  logic [4:0]  rx_dec;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      signal_detect_out <= 1'b0;
      rx_nrzi           <= 1'b0;
      rx_prev           <= 1'b0;
    end else begin
      signal_detect_out <= rx_energy_in && !rx_link_pulse_in;
      rx_nrzi           <= rx_line_in.pos || rx_line_in.neg;
      rx_prev           <= rx_nrzi;
    end
  end

  assign rx_nrz  = rx_nrzi ^ rx_prev;
  assign dsc_key = dsc[`FEPC_TAP_HI] ^ dsc[`FEPC_TAP_LO];
  assign ud      = rx_nrz ^ dsc_key;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dsc           <= '0;
      lock_run      <= 6'h00;
      mon_run       <= 6'h00;
      hold          <= '0;
      rx_locked_out <= 1'b0;
    end else if (!signal_detect_out) begin
      lock_run      <= 6'h00;
      mon_run       <= 6'h00;
      rx_locked_out <= 1'b0;
    end else if (!rx_locked_out) begin
      // idle is all ones, so the key is the inverted line bit
      dsc <= {dsc[9:0], !rx_nrz};
      if (ud) begin
        lock_run <= lock_run + 6'h01;
      end else begin
        lock_run <= 6'h00;
      end
      if (ud && lock_run == LOCK_LAST) begin
        rx_locked_out <= 1'b1;
        hold          <= HOLD_LOAD;
        mon_run       <= 6'h00;
      end
    end else begin
      dsc <= {dsc[9:0], dsc_key};
      if (ud && mon_run == MON_LAST) begin
        mon_run <= 6'h00;
        hold    <= HOLD_LOAD;
      end else begin
        mon_run <= ud ? mon_run + 6'h01 : 6'h00;
        if (hold == '0) begin
          rx_locked_out <= 1'b0;
          lock_run      <= 6'h00;
          dsc           <= '0;
        end else begin
          hold <= hold - HOLD_W'(1);
        end
      end
    end
  end

  assign next_rx_sym = {rx_acc, ud};
  assign rx_dec      = fepc_decode(next_rx_sym);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_cnt            <= 3'h0;
      rx_acc            <= 4'h0;
      rx_word_out       <= '0;
      rx_word_valid_out <= 1'b0;
    end else begin
      rx_word_valid_out <= 1'b0;
      if (!rx_locked_out || !signal_detect_out) begin
        rx_cnt <= 3'h0;
      end else begin
        rx_acc <= next_rx_sym[3:0];
        if (rx_cnt == 3'h4) begin
          rx_cnt            <= 3'h0;
          rx_word_valid_out <= 1'b1;
          rx_word_out       <= '{sym: next_rx_sym, nib: rx_dec[3:0], is_data: rx_dec[4]};
        end else begin
          rx_cnt <= rx_cnt + 3'h1;
        end
      end
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  start_delim_a: assert property (
    boundary && (tx_state == TX_IDLE || tx_state == TX_R) && head_valid && head.en
    |=> (tx_sym == `FEPC_CODE_J) ##5 (tx_sym == `FEPC_CODE_K))
    else $error("start delimiter J K not sent");

  end_delim_a: assert property (
    boundary && (tx_state == TX_DATA) && !(head_valid && head.en)
    |=> (tx_sym == `FEPC_CODE_T) ##5 (tx_sym == `FEPC_CODE_R))
    else $error("end delimiter T R not sent");

  data_code_a: assert property (
    boundary && (tx_state == TX_DATA) && head_valid && head.en
    |=> tx_sym == fepc_encode($past(head.nib)))
    else $error("data nibble wrongly encoded");

  idle_fill_a: assert property (
    tx_state == TX_IDLE |-> tx_sym == `FEPC_CODE_IDLE)
    else $error("idle state sends non-idle group");

  mlt_split_a: assert property (
    tx_line_out.pos |-> !tx_line_out.neg && !$past(phase) ##1 !tx_line_out.neg)
    else $error("MLT-3 streams out of phase");

  scr_nonzero_a: assert property (
    scr != 11'h000)
    else $error("scrambler state collapsed to zero");

  sig_pulse_a: assert property (
    rx_link_pulse_in |=> !signal_detect_out)
    else $error("signal detect on link pulses");

  lock_start_a: assert property (
    $rose(rx_locked_out) |-> $past(lock_run) == LOCK_LAST && hold == HOLD_LOAD)
    else $error("lock without twelve idles or hold load");

  hold_restart_a: assert property (
    rx_locked_out && signal_detect_out && ud && mon_run == MON_LAST
    |=> hold == HOLD_LOAD)
    else $error("hold timer not restarted");

  hold_expire_a: assert property (
    rx_locked_out && signal_detect_out && hold == '0 && !(ud && mon_run == MON_LAST)
    |=> !rx_locked_out && lock_run == 6'h00)
    else $error("lock kept after hold expiry");

  sym_space_a: assert property (
    rx_word_valid_out |=> !rx_word_valid_out [*4])
    else $error("symbols closer than five bits");

  frame_c:  cover property (tx_state == TX_R);
  lock_c:   cover property ($rose(rx_locked_out));
  expire_c: cover property ($fell(rx_locked_out) && signal_detect_out);
  full_c:   cover property (!mac_tx_ready_out && head_valid);

endmodule // fepc_core

`default_nettype wire

// ### verif/fepc_link_partner.sv
/*
  Far-end model: recovers transmitted code-groups from the MLT-3 pair and
  sources a scrambled MLT-3 line stream. Assumes one line bit per clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fepc_params.svh"

module fepc_link_partner
  import fepc_pkg::*;
#(
  parameter logic [10:0] SEED = 11'h2a5
) (
  input  wire logic       clk_in,        // bit clock
  input  wire logic       reset_n_in,    // async reset, low
  input  wire fepc_line_t tx_line_in,    // block transmit pair
  input  wire logic       idle_in,       // send idle, else zeros
  input  wire logic       on_in,         // drive the line
  output fepc_line_t      rx_line_out,   // pair towards block
  output logic [4:0]      sym_out,       // recovered code-group
  output logic            sym_valid_out, // one-cycle strobe
  output logic            line_err_out   // pair coding broken
);
  logic [10:0] key_h, gen;
  logic [9:0]  pl;
  logic [4:0]  cnt;
  logic [2:0]  bit_n;
  logic        lvl, last_pos, framing, pol, glvl;
  logic        one, sd, k, ud, gk, gsd, nl, np;

  always_comb begin
    one = tx_line_in.pos | tx_line_in.neg;
    sd  = one ^ lvl;
    // training assumes idle plaintext; later the key runs on its own
    k   = (cnt < 5'd31) ? ~sd : key_h[10] ^ key_h[8];
    ud  = sd ^ k;
    gk  = gen[10] ^ gen[8];
    gsd = idle_in ^ gk;
    nl  = glvl ^ gsd;
    np  = (nl & ~glvl) ? ~pol : pol;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lvl           <= 1'b0;
      key_h         <= '0;
      cnt           <= '0;
      pl            <= '0;
      framing       <= 1'b0;
      bit_n         <= '0;
      last_pos      <= 1'b0;
      sym_out       <= '0;
      sym_valid_out <= 1'b0;
      line_err_out  <= 1'b0;
    end else begin
      lvl           <= one;
      key_h         <= {key_h[9:0], k};
      pl            <= {pl[8:0], ud};
      sym_valid_out <= 1'b0;
      // polarity flips per run of ones, never both legs at once
      line_err_out  <= (tx_line_in.pos & tx_line_in.neg) |
                       (one & ((tx_line_in.pos == last_pos) ^ lvl));
      if (one) begin
        last_pos <= tx_line_in.pos;
      end
      if (cnt < 5'd31) begin
        cnt <= cnt + 5'd1;
      end
      if (!framing && cnt == 5'd31 &&
          {pl[8:0], ud} == {`FEPC_CODE_J, `FEPC_CODE_K}) begin
        framing       <= 1'b1;
        bit_n         <= 3'd0;
        sym_out       <= `FEPC_CODE_K;
        sym_valid_out <= 1'b1;
      end else if (framing) begin
        bit_n <= (bit_n == 3'd4) ? 3'd0 : bit_n + 3'd1;
        if (bit_n == 3'd4) begin
          sym_out       <= {pl[3:0], ud};
          sym_valid_out <= 1'b1;
          if ({pl[3:0], ud} == `FEPC_CODE_R) begin
            framing <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gen         <= SEED;
      glvl        <= 1'b0;
      pol         <= 1'b0;
      rx_line_out <= '0;
    end else begin
      gen         <= {gen[9:0], gk};
      glvl        <= nl;
      pol         <= np;
      rx_line_out <= on_in ? {nl & np, nl & ~np} : 2'b00;
    end
  end
endmodule // fepc_link_partner
`default_nettype wire

// ### verif/fast_ethernet_pcs_coding_test.sv
/*
  Self-checking bench of the coding path: frames through the encoder,
  idle traffic into the descrambler. Assumes fepc_link_partner as far end.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fepc_params.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module fast_ethernet_pcs_coding_test;
  import fepc_pkg::*;
  localparam int HOLD = 200;
  localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic           clk_in = 1'b0, reset_n_in = 1'b0, mac_tx_valid_in = 1'b0;
  logic           rx_energy_in = 1'b0, rx_link_pulse_in = 1'b0, p_idle = 1'b1;
  logic           p_on = 1'b0, chk_rx = 1'b0, rdy_s = 1'b0, stall_seen = 1'b0;
  logic           lost = 1'b0, chk_zero = 1'b0;
  logic [4:0]     straps = '0;
  fepc_mac_word_t mac_tx_in = '0;
  fepc_line_t     tx_line, rx_line;
  logic           mac_tx_ready, sig_det, locked, word_valid, p_valid, p_err;
  fepc_rx_word_t  word;
  logic [4:0]     p_sym, e_sym;
  logic [4:0]     exp_q [$];
  int             n_errors = 0;
  int             checked = 0;
  int             rx_words = 0;

  always #12.5 clk_in = ~clk_in;

  fepc_core #(.HOLD_CYCLES(HOLD), .BUF_DEPTH(2)) dut_u (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .station_address_straps_in(straps),
    .mac_tx_in(mac_tx_in), .mac_tx_valid_in(mac_tx_valid_in),
    .mac_tx_ready_out(mac_tx_ready), .tx_line_out(tx_line), .rx_line_in(rx_line),
    .rx_energy_in(rx_energy_in), .rx_link_pulse_in(rx_link_pulse_in),
    .signal_detect_out(sig_det), .rx_locked_out(locked), .rx_word_out(word),
    .rx_word_valid_out(word_valid));

  fepc_link_partner partner_u (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .tx_line_in(tx_line),
    .idle_in(p_idle), .on_in(p_on), .rx_line_out(rx_line), .sym_out(p_sym),
    .sym_valid_out(p_valid), .line_err_out(p_err));

  // registered outputs are settled at the falling edge
  always @(negedge clk_in) begin
    rdy_s = mac_tx_ready;
    if (mac_tx_valid_in && !mac_tx_ready) stall_seen = 1'b1;
    if (p_err) `CHK(p_err, 1'b0)
    if (p_valid) begin
      if (exp_q.size() == 0) `CHK(p_sym, 5'h00)
      else begin
        e_sym = exp_q.pop_front();
        `CHK(p_sym, e_sym)
      end
    end
    if (word_valid && chk_rx) begin
      rx_words++;
      `CHK(word.sym, `FEPC_CODE_IDLE)
      `CHK(word.is_data, 1'b0)
      `CHK(word.nib, 4'h0)
    end
    // locked key on zero plaintext must give all-zero symbols
    if (word_valid && chk_zero) begin
      `CHK(word.sym, 5'h00)
      `CHK(word.is_data, 1'b0)
    end
  end

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // entered and left 2 ns after a rising edge
  task automatic send(input logic en, input logic [3:0] nib);
    mac_tx_in       = '{en: en, nib: nib};
    mac_tx_valid_in = 1'b1;
    do @(posedge clk_in); while (!rdy_s);
    #2;
  endtask

  task automatic frame(input int n);
    logic [3:0] d;
    send(1'b1, 4'h5);
    send(1'b1, 4'h5);
    exp_q.push_back(`FEPC_CODE_K);
    for (int i = 0; i < n; i++) begin
      d = (i < 16) ? i[3:0] : 4'($urandom);
      exp_q.push_back(CODE[d]);
      send(1'b1, d);
    end
    exp_q.push_back(`FEPC_CODE_T);
    exp_q.push_back(`FEPC_CODE_R);
    send(1'b0, 4'h0);
    mac_tx_valid_in = 1'b0;
  endtask

  task automatic wait_lock(input logic want, input int lim);
    for (int i = 0; i < lim && locked !== want; i++) @(negedge clk_in);
    @(posedge clk_in);
    #2;
  endtask

  initial begin
    void'($urandom(17904));
    straps = 5'($urandom);
    repeat (20) @(posedge clk_in);
    #2;
    reset_n_in = 1'b1;
    // far end trains its key on the idle fill first
    repeat (300) @(posedge clk_in);
    #2;
    frame(24);
    repeat (40) @(posedge clk_in);
    #2;
    send(1'b0, 4'h3);
    mac_tx_valid_in = 1'b0;
    @(posedge clk_in);
    #2;
    frame(3);
    repeat (80) @(posedge clk_in);
    `CHK(exp_q.size(), 0)
    `CHK(stall_seen, 1'b1)
    #2;
    p_on         = 1'b1;
    rx_energy_in = 1'b1;
    wait_lock(1'b1, 300);
    `CHK(sig_det, 1'b1)
    `CHK(locked, 1'b1)
    chk_rx = 1'b1;
    repeat (3 * HOLD) begin
      @(negedge clk_in);
      if (locked !== 1'b1) lost = 1'b1;
    end
    `CHK(lost, 1'b0)
    `CHK(rx_words > 100, 1'b1)
    @(posedge clk_in);
    #2;
    chk_rx = 1'b0;
    p_idle = 1'b0;
    // let the idle bits already in the pipe drain before judging symbols
    repeat (10) @(posedge clk_in);
    #2;
    chk_zero = 1'b1;
    wait_lock(1'b0, HOLD + 100);
    chk_zero = 1'b0;
    `CHK(locked, 1'b0)
    p_idle = 1'b1;
    wait_lock(1'b1, 300);
    `CHK(locked, 1'b1)
    rx_link_pulse_in = 1'b1;
    repeat (3) @(negedge clk_in);
    `CHK(sig_det, 1'b0)
    `CHK(locked, 1'b0)
    report_and_stop();
  end

  initial begin
    repeat (12000) @(posedge clk_in);
    n_errors++;
    report_and_stop();
  end
endmodule // fast_ethernet_pcs_coding_test
`undef CHK
`default_nettype wire
